// file: shared/irq_seq_pkg.sv
// Purpose : shared constants and types for the interrupt sequencer
// Assumes : single cpu clock, 22-bit program counter, 16-bit stack pointer
// Notes   : vector numbers count from one; vector zero is reset
package irq_seq_pkg;

    // ------------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------------
    localparam int PC_W        = 22;          // program counter width
    localparam int SP_W        = 16;          // stack pointer width
    localparam int NUM_SRC     = 8;           // default number of sources
    localparam int VEC_W       = 5;           // vector number width

    // ------------------------------------------------------------------
    // vector layout
    // ------------------------------------------------------------------
    localparam logic [PC_W-1:0] APP_BASE    = 22'h000000; // lowest flash
    localparam logic [PC_W-1:0] VEC_STRIDE  = 22'h000002; // words per vector
    localparam logic [VEC_W-1:0] RESET_VEC  = 5'h00;      // reset slot

    // ------------------------------------------------------------------
    // timing counts in cpu cycles
    // ------------------------------------------------------------------
    localparam logic [3:0] ENTRY_CYC    = 4'h5;   // entry, pc push
    localparam logic [3:0] WAKE_EXTRA   = 4'h5;   // extra when asleep
    localparam logic [3:0] RETURN_CYC   = 4'h5;   // return, pc pop
    localparam logic [3:0] ONE_CYC      = 4'h1;   // last cycle marker
    localparam logic [SP_W-1:0] PC_BYTES = 16'h0003; // bytes per pc

    // ------------------------------------------------------------------
    // sequencer states, one-hot
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        IDLE_ST   = 4'b0001,  // running main code
        ENTRY_ST  = 4'b0010,  // pushing pc, counting entry cycles
        RETURN_ST = 4'b0100,  // popping pc, counting return cycles
        HOLD_ST   = 4'b1000   // one main instruction before next entry
    } seq_state_type;

    // core handshake from the pipeline
    typedef struct packed {
        logic insnBoundary;   // current instruction completes this cycle
        logic disableInstr;   // global_irq_disable_instr executes
        logic enableInstr;    // global enable set instruction executes
        logic returnInstr;    // irq_return_instr executes
        logic sleeping;       // core in sleep mode
    } core_evt_type;

endpackage : irq_seq_pkg

// file: hdl/irq_prio_pick.sv
// Purpose : fixed priority picker, lowest index wins
// Assumes : request vector already gated
// Notes   : purely combinational
`timescale 1ns/10ps
module irq_prio_pick
    import irq_seq_pkg::*;
#(
    parameter int N = NUM_SRC
) (
    input  wire logic [N-1:0]     req,     // gated requests
    output logic                  any,     // some request present
    output logic [N-1:0]          grant    // one-hot winner
);
    // ------------------------------------------------------------------
    // prefix of higher priority requests
    // ------------------------------------------------------------------
    logic [N:0] above;                     // any lower index requesting

    assign above[0] = 1'b0;
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_pick
            assign above[i+1] = above[i] | req[i];
            assign grant[i]   = req[i] & ~above[i];  // RULE4 RULE23
        end
    endgenerate
    assign any = above[N];
endmodule : irq_prio_pick

// file: hdl/irq_flag_bank.sv
// Purpose : per-source sticky flags and level requests
// Assumes : flag sources pulse for one cycle per event
// Notes   : set wins over any clear in the same cycle
`timescale 1ns/10ps
module irq_flag_bank
    import irq_seq_pkg::*;
#(
    parameter int N = NUM_SRC
) (
    input  wire logic         clock,      // cpu clock
    input  wire logic         rstSync_b,  // synchronised reset, low
    input  wire logic         clockEn,    // freeze when low
    input  wire logic [N-1:0] isLevel,    // source is level type
    input  wire logic [N-1:0] srcEvent,   // event or level condition
    input  wire logic [N-1:0] swClear,    // write-one-to-clear strobes
    input  wire logic [N-1:0] hwClear,    // vectored source clear
    output logic      [N-1:0] pending     // request per source
);
    logic [N-1:0] flag_q;                 // sticky flags
    logic [N-1:0] flag_d;                 // next flags

    // ------------------------------------------------------------------
    // flag update per source
    // ------------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_flag
            // events always latch, whether enabled or not
            assign flag_d[i] = ~isLevel[i] & (srcEvent[i] |      // RULE11
                (flag_q[i] & ~swClear[i] & ~hwClear[i]));    // RULE9 RULE10
            // level sources request only while present, no memory
            assign pending[i] = isLevel[i] ? srcEvent[i]        // RULE13
                                           : flag_q[i];         // RULE12
        end
    endgenerate

    // flags register
    always_ff @(posedge clock or negedge rstSync_b) begin
        if (!rstSync_b) begin
            flag_q <= '0;
        end else if (clockEn) begin
            flag_q <= flag_d;
        end
    end
endmodule : irq_flag_bank

// file: hdl/cpu_interrupt_sequencer.sv
// Purpose : interrupt acceptance and entry/return sequencing for the cpu
// Assumes : pipeline reports instruction boundaries and special opcodes
// Notes   : stack memory writes are done by the core from pushReq/popReq
//
// Summary of operation
// RULE1: need source enable and global enable
// RULE2: lock bits block interrupts by pc area
// RULE3: reset and vectors at lowest addresses
// RULE4: lower vector address has higher priority
// RULE5: select bit moves vectors to boot
// RULE6: boot fuse moves reset vector to boot
// RULE7: acceptance clears global enable
// RULE8: return instruction sets global enable
// RULE9: vectoring clears the source flag
// RULE10: writing one clears a flag
// RULE11: disabled source still sets its flag
// RULE12: pending flags served later by priority
// RULE13: level requests only while present
// RULE14: one main instruction after return
// RULE15: status register not saved or restored
// RULE16: disable instruction blocks same-cycle interrupts
// RULE17: instruction after enable runs first
// RULE18: entry takes five cycles, pushes pc
// RULE19: multi-cycle instruction finishes before entry
// RULE20: wake from sleep adds five cycles
// RULE21: return five cycles, pop, sp plus three
// RULE22: entry push lowers sp by three
// RULE23: one lowest vector chosen, rest pending
`timescale 1ns/10ps
module cpu_interrupt_sequencer
    import irq_seq_pkg::*;
#(
    parameter int N = NUM_SRC
) (
    input  wire logic            clock,          // cpu clock
    input  wire logic            rst_b,          // async reset, low
    input  wire logic            clockEn,        // freeze when low
    input  wire logic [N-1:0]    srcEvent,       // request lines
    input  wire logic [N-1:0]    isLevel,        // per source type
    input  wire logic [N-1:0]    srcEnable,      // per source enable
    input  wire logic [N-1:0]    flagWrite1,     // write-one-to-clear
    input  wire core_evt_type    coreEvt,        // pipeline events
    input  wire logic            globalEnWr,     // software writes i-bit
    input  wire logic            globalEnVal,    // value written
    input  wire logic            vector_table_select, // vectors in boot
    input  wire logic            reset_vector_boot_fuse, // reset in boot
    input  wire logic            app_area_lock_bit,  // lock on app area
    input  wire logic            boot_area_lock_bit, // lock on boot area
    input  wire logic [PC_W-1:0] bootBase,       // boot section start
    input  wire logic [PC_W-1:0] curPc,          // current pc
    input  wire logic [SP_W-1:0] curSp,          // current stack pointer
    output logic                 globalEn,       // i-bit state
    output logic                 stallCore,      // core held in sequence
    output logic                 pushReq,        // push pc in progress
    output logic                 popReq,         // pop pc in progress
    output logic                 spLoad,         // load newSp this cycle
    output logic [SP_W-1:0]      newSp,          // updated stack pointer
    output logic                 pcLoad,         // load newPc this cycle
    output logic [PC_W-1:0]      newPc,          // vector or reset target
    output logic [N-1:0]         pendingOut      // visible requests
);
    // ------------------------------------------------------------------
    // reset synchroniser
    // ------------------------------------------------------------------
    logic rstMeta_q;                        // first stage, read by second
    logic rstSync_q;                        // released reset for design

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rstMeta_q <= 1'b0;
            rstSync_q <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstSync_q <= rstMeta_q;
        end
    end

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    seq_state_type   state_q, state_d;     // sequencer state
    logic [3:0]      cnt_q, cnt_d;         // cycles left in phase
    logic            gie_q, gie_d;         // global enable
    logic            seiDelay_q;           // enable instr shadow
    logic [N-1:0]    grant_q;              // latched winner
    logic [N-1:0]    pend;                 // requests from flag bank
    logic [N-1:0]    gated;                // enabled requests
    logic [N-1:0]    grant;                // combinational winner
    logic [N-1:0]    hwClr;                // flag clear on vectoring
    logic            anyReq;               // some enabled request
    logic            pcInBoot;             // pc inside boot section
    logic            lockBlock;            // lock bits forbid interrupts
    logic            accept;               // take interrupt now
    logic            firstPc;              // first cycle after reset
    logic [VEC_W-1:0] vecNum;              // winning vector number
    logic [PC_W-1:0] vecBase;              // table base address
    logic [PC_W-1:0] vecAddr;              // computed vector address
    logic [PC_W-1:0] rstAddr;              // reset vector address
    logic [3:0]      entryLen;             // entry length incl. wake
    logic            lastCyc;              // final counted cycle
    logic            bootDone_q;           // reset vector issued

    logic            globalEn_q, stall_q, push_q, pop_q;
    logic            spLoad_q, pcLoad_q;
    logic [SP_W-1:0] newSp_q;
    logic [PC_W-1:0] newPc_q;
    logic [N-1:0]    pendOut_q;

    // ------------------------------------------------------------------
    // flag storage and priority
    // ------------------------------------------------------------------
    irq_flag_bank #(.N(N)) u_flags (
        .clock     (clock),
        .rstSync_b (rstSync_q),
        .clockEn   (clockEn),
        .isLevel   (isLevel),
        .srcEvent  (srcEvent),
        .swClear   (flagWrite1),
        .hwClear   (hwClr),
        .pending   (pend)
    );

    irq_prio_pick #(.N(N)) u_pick (
        .req   (gated),
        .any   (anyReq),
        .grant (grant)
    );

    // ------------------------------------------------------------------
    // acceptance decode
    // ------------------------------------------------------------------
    // lock bits guard the section the pc is running in
    assign pcInBoot  = (curPc >= bootBase);
    assign lockBlock = pcInBoot ? boot_area_lock_bit
                                : app_area_lock_bit;           // RULE2
    assign gated     = pend & srcEnable;                       // RULE1
    // disable instruction masks in its own cycle; enable waits a slot
    assign accept    = (state_q == IDLE_ST) & gie_q & anyReq   // RULE1
                     & ~lockBlock & ~coreEvt.disableInstr      // RULE16
                     & ~seiDelay_q & ~coreEvt.enableInstr      // RULE17
                     & coreEvt.insnBoundary;                   // RULE19
    // clear only the one chosen flag; others keep waiting
    assign hwClr     = accept ? (grant & ~isLevel) : '0;      // RULE9 RULE23

    // winner index to vector number, vector zero is reset
    always_comb begin
        vecNum = RESET_VEC;
        for (int k = N - 1; k >= 0; k--) begin
            if (grant_q[k]) begin
                vecNum = VEC_W'(k + 1);                        // RULE3
            end
        end
    end

    assign vecBase  = vector_table_select ? bootBase : APP_BASE; // RULE5
    assign vecAddr  = vecBase + PC_W'(vecNum) * VEC_STRIDE;    // RULE3 RULE4
    assign rstAddr  = reset_vector_boot_fuse ? bootBase
                                             : APP_BASE;       // RULE6
    assign entryLen = coreEvt.sleeping ? ENTRY_CYC + WAKE_EXTRA
                                       : ENTRY_CYC;            // RULE20
    assign lastCyc  = (cnt_q == ONE_CYC);
    assign firstPc  = ~bootDone_q;

    // ------------------------------------------------------------------
    // sequencer next state
    // ------------------------------------------------------------------
    // status register is never touched here; software keeps it (RULE15)
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        gie_d   = gie_q;
        if (globalEnWr) begin
            gie_d = globalEnVal;           // software write of i-bit
        end
        if (coreEvt.disableInstr) begin
            gie_d = 1'b0;                                      // RULE16
        end
        if (coreEvt.enableInstr) begin
            gie_d = 1'b1;
        end
        case (state_q)
            IDLE_ST: begin
                if (accept) begin
                    state_d = ENTRY_ST;
                    cnt_d   = entryLen;                        // RULE18
                    gie_d   = 1'b0;                            // RULE7
                end else if (coreEvt.returnInstr) begin
                    state_d = RETURN_ST;
                    cnt_d   = RETURN_CYC;                      // RULE21
                end
            end
            ENTRY_ST: begin
                cnt_d = cnt_q - ONE_CYC;
                if (lastCyc) begin
                    state_d = IDLE_ST;     // vector runs next
                end
            end
            RETURN_ST: begin
                cnt_d = cnt_q - ONE_CYC;
                if (lastCyc) begin
                    state_d = HOLD_ST;
                    gie_d   = 1'b1;                            // RULE8
                end
            end
            HOLD_ST: begin
                // wait for one whole main instruction to finish
                if (coreEvt.insnBoundary) begin
                    state_d = IDLE_ST;                         // RULE14
                end
            end
            default: begin
                state_d = IDLE_ST;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // sequencer state registers
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rstSync_q) begin
        if (!rstSync_q) begin
            state_q    <= IDLE_ST;
            cnt_q      <= '0;
            gie_q      <= 1'b0;
            seiDelay_q <= 1'b0;
            grant_q    <= '0;
            bootDone_q <= 1'b0;
        end else if (clockEn) begin
            state_q    <= state_d;
            cnt_q      <= cnt_d;
            gie_q      <= gie_d;
            bootDone_q <= 1'b1;
            // shadow lasts until the following instruction completes
            if (coreEvt.enableInstr) begin
                seiDelay_q <= 1'b1;                            // RULE17
            end else if (coreEvt.insnBoundary) begin
                seiDelay_q <= 1'b0;
            end
            if (accept) begin
                grant_q <= grant;                              // RULE23
            end
        end
    end

    // ------------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------------
    // pc load comes the cycle after the last entry cycle, or once after reset
    always_ff @(posedge clock or negedge rstSync_q) begin
        if (!rstSync_q) begin
            globalEn_q <= 1'b0;
            stall_q    <= 1'b0;
            push_q     <= 1'b0;
            pop_q      <= 1'b0;
            spLoad_q   <= 1'b0;
            newSp_q    <= '0;
            pcLoad_q   <= 1'b0;
            newPc_q    <= '0;
            pendOut_q  <= '0;
        end else if (clockEn) begin
            globalEn_q <= gie_d;
            stall_q    <= (state_d == ENTRY_ST) | (state_d == RETURN_ST);
            push_q     <= (state_d == ENTRY_ST);               // RULE18
            pop_q      <= (state_d == RETURN_ST);              // RULE21
            spLoad_q   <= accept | (state_q == RETURN_ST & lastCyc);
            if (accept) begin
                newSp_q <= curSp - PC_BYTES;                   // RULE22
            end else if (state_q == RETURN_ST && lastCyc) begin
                newSp_q <= curSp + PC_BYTES;                   // RULE21
            end
            pcLoad_q   <= firstPc | (state_q == ENTRY_ST & lastCyc);
            if (firstPc) begin
                newPc_q <= rstAddr;                            // RULE6
            end else if (state_q == ENTRY_ST && lastCyc) begin
                newPc_q <= vecAddr;                            // RULE5
            end
            pendOut_q  <= pend;                                // RULE12
        end
    end

    assign globalEn   = globalEn_q;
    assign stallCore  = stall_q;
    assign pushReq    = push_q;
    assign popReq     = pop_q;
    assign spLoad     = spLoad_q;
    assign newSp      = newSp_q;
    assign pcLoad     = pcLoad_q;
    assign newPc      = newPc_q;
    assign pendingOut = pendOut_q;
endmodule : cpu_interrupt_sequencer

// file: sim/cpu_interrupt_sequencer_assertions.sv
// Purpose : timing checks on the interrupt sequencer ports
// Assumes : one clock domain, core retires one instruction a cycle
// Notes   : bounds follow the entry and return walks
`timescale 1ns/10ps
module cpu_interrupt_sequencer_assertions
    import irq_seq_pkg::*;
#(
    parameter int N = NUM_SRC
) (
    input wire logic            clock,
    input wire logic            rst_b,
    input wire core_evt_type    coreEvt,
    input wire logic            globalEnWr,
    input wire logic [SP_W-1:0] curSp,
    input wire logic            globalEn,
    input wire logic            stallCore,
    input wire logic            pushReq,
    input wire logic            popReq,
    input wire logic            spLoad,
    input wire logic [SP_W-1:0] newSp,
    input wire logic            pcLoad
);
    // ------------------------------------------------------------
    // sequencing checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    ie_gate_a:
        assert property ($rose(pushReq) |-> $past(globalEn) && !globalEn)
        else $error("entry without global enable or enable kept");
    push_sp_a:
        assert property ($rose(pushReq) |-> spLoad && newSp == curSp - 3)
        else $error("entry stack pointer not lowered by three");
    entry_len_a:
        assert property ($rose(pushReq) && !$past(coreEvt.sleeping)
            |-> !pcLoad[*5] ##1 pcLoad)
        else $error("entry vector not loaded after five cycles");
    wake_len_a:
        assert property ($rose(pushReq) && $past(coreEvt.sleeping)
            |-> ##10 pcLoad)
        else $error("wake entry not ten cycles");
    pop_sp_a:
        assert property ($rose(popReq)
            |-> ##5 (spLoad && newSp == curSp + 3))
        else $error("return stack pointer not raised by three");
    ret_ie_a:
        assert property ($rose(popReq) |-> ##[4:6] globalEn)
        else $error("return did not set global enable");
    ret_gap_a:
        assert property ($fell(popReq) |-> !pushReq[*2])
        else $error("entry without a main instruction after return");
    dis_block_a:
        assert property (coreEvt.disableInstr && !coreEvt.enableInstr
            && !globalEnWr && !stallCore |=> !globalEn && !pushReq)
        else $error("interrupt taken after disable instruction");
    en_shadow_a:
        assert property (coreEvt.enableInstr && !stallCore
            |=> !pushReq[*2])
        else $error("entry before instruction after enable");
endmodule : cpu_interrupt_sequencer_assertions

// file: sim/core_pipe_model.sv
// Purpose : behavioural cpu core facing the sequencer
// Assumes : every instruction takes one cycle
// Notes   : multi-cycle instructions are not modelled
`timescale 1ns/10ps
module core_pipe_model
    import irq_seq_pkg::*;
(
    input  wire logic            clock,
    input  wire logic            stallCore,
    input  wire logic            pcLoad,
    input  wire logic [PC_W-1:0] newPc,
    input  wire logic            spLoad,
    input  wire logic [SP_W-1:0] newSp,
    output logic                 insnBoundary,
    output logic      [PC_W-1:0] curPc = 22'h000000,
    output logic      [SP_W-1:0] curSp = 16'h10ff
);
    // ------------------------------------------------------------
    // program flow
    // ------------------------------------------------------------
    // one instruction retires a cycle unless the sequencer holds us
    assign insnBoundary = !stallCore;
    // pc and sp follow loads
    always @(posedge clock) begin
        if (pcLoad) curPc <= newPc;
        else if (insnBoundary) curPc <= curPc + 22'h000001;
        if (spLoad) curSp <= newSp;
    end
endmodule : core_pipe_model

// file: sim/tb_top.sv
// Purpose : directed test of the interrupt sequencer
// Assumes : core model retires one instruction a cycle
// Notes   : inputs change on the falling edge
`timescale 1ns/10ps
module tb_top
    import irq_seq_pkg::*;
;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam logic [PC_W-1:0] BOOT = 22'h01f000; // boot start
    localparam logic [SP_W-1:0] SP0  = 16'h10ff;   // model sp
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] srcEvent, isLevel, srcEnable, flagWrite1, pendingOut;
    logic insnBoundary, disableInstr, enableInstr, returnInstr, sleeping;
    logic globalEnWr, globalEnVal, vts, fuse, appLock, bootLock;
    logic globalEn, stallCore, pushReq, popReq, spLoad, pcLoad;
    logic [SP_W-1:0] newSp, curSp;
    logic [PC_W-1:0] newPc, curPc;
    core_evt_type    coreEvt;
    int              badCount, checksDone;
    assign coreEvt = {insnBoundary, disableInstr, enableInstr,
                      returnInstr, sleeping};
    always #5 clock = ~clock;
    cpu_interrupt_sequencer cpu_interrupt_sequencer_i (
        .clock(clock), .rst_b(rst_b), .clockEn(1'b1),
        .srcEvent(srcEvent), .isLevel(isLevel), .srcEnable(srcEnable),
        .flagWrite1(flagWrite1), .coreEvt(coreEvt),
        .globalEnWr(globalEnWr), .globalEnVal(globalEnVal),
        .vector_table_select(vts), .reset_vector_boot_fuse(fuse),
        .app_area_lock_bit(appLock), .boot_area_lock_bit(bootLock),
        .bootBase(BOOT), .curPc(curPc), .curSp(curSp),
        .globalEn(globalEn), .stallCore(stallCore), .pushReq(pushReq),
        .popReq(popReq), .spLoad(spLoad), .newSp(newSp),
        .pcLoad(pcLoad), .newPc(newPc), .pendingOut(pendingOut));
    core_pipe_model core_pipe_model_i (
        .clock(clock), .stallCore(stallCore), .pcLoad(pcLoad),
        .newPc(newPc), .spLoad(spLoad), .newSp(newSp),
        .insnBoundary(insnBoundary), .curPc(curPc), .curSp(curSp));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checksDone++;
        if (seen !== exp) begin
            badCount++;
            $display("unexpected at %0t: %h vs %h", $time, seen, exp);
        end
    endtask : chk
    task automatic finishTest();
        if (badCount == 0 && checksDone > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : finishTest
    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask : tick
    // hold reset, expect the reset vector load
    task automatic doReset(input logic [PC_W-1:0] pc);
        int k;
        rst_b = 1'b0;
        tick(8);
        rst_b = 1'b1;
        for (k = 0; k < 10 && !pcLoad; k++) tick(1);
        chk({pcLoad, newPc}, {1'b1, pc});
        tick(4);
    endtask : doReset
    task automatic hit(input int s);
        srcEvent[s] = 1'b1;
        tick(1);
        srcEvent[s] = 1'b0;
    endtask : hit
    // wait for an entry, then time it up to the vector load
    task automatic take(input logic [PC_W-1:0] pc, input int len);
        int n;
        for (n = 0; n < 40 && !stallCore; n++) tick(1);
        for (n = 0; n < 40 && !pcLoad; n++) tick(1);
        chk({pcLoad, newPc}, {1'b1, pc});
        chk(n, len);
        chk(globalEn, 1'b0);
    endtask : take
    task automatic ret();
        int n;
        returnInstr = 1'b1;
        tick(1);
        returnInstr = 1'b0;
        for (n = 0; n < 20 && !popReq; n++) tick(1);
        for (n = 0; n < 20 && popReq; n++) tick(1);
        chk(globalEn, 1'b1);
        tick(1);
        chk(curSp, SP0);
    endtask : ret
    task automatic quiet(input int n);
        repeat (n) begin
            tick(1);
            chk(stallCore, 1'b0);
        end
    endtask : quiet
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        badCount = 0;
        checksDone = 0;
        {srcEvent, flagWrite1} = '0;
        {disableInstr, enableInstr, returnInstr, sleeping} = '0;
        {globalEnWr, globalEnVal, vts, fuse, appLock, bootLock} = '0;
        isLevel = 8'h08;
        srcEnable = 8'h2f;
        doReset(APP_BASE);
        fuse = 1'b1;
        doReset(BOOT);
        fuse = 1'b0;
        {globalEnWr, globalEnVal} = 2'b11;
        tick(1);
        globalEnWr = 1'b0;
        hit(2);
        take(APP_BASE + 22'h000006, 5);
        chk(pendingOut[2], 1'b0);
        ret();
        // disable in the same cycle as a request
        {disableInstr, srcEvent[0]} = 2'b11;
        tick(1);
        {disableInstr, srcEvent[0]} = 2'b00;
        quiet(12);
        hit(5);
        hit(1);
        hit(6);
        tick(2);
        chk(pendingOut, 8'h63);
        enableInstr = 1'b1;
        tick(1);
        enableInstr = 1'b0;
        take(APP_BASE + 22'h000002, 5);
        ret();
        take(APP_BASE + 22'h000004, 5);
        ret();
        take(APP_BASE + 22'h00000c, 5);
        chk(pendingOut[6], 1'b1);
        flagWrite1 = 8'h40;
        tick(1);
        flagWrite1 = '0;
        tick(2);
        chk(pendingOut[6], 1'b0);
        ret();
        // app area lock holds off a request until unlocked
        appLock = 1'b1;
        hit(2);
        quiet(12);
        appLock = 1'b0;
        take(APP_BASE + 22'h000006, 5);
        srcEvent[3] = 1'b1;
        tick(3);
        srcEvent[3] = 1'b0;
        tick(2);
        ret();
        quiet(12);
        vts = 1'b1;
        hit(2);
        take(BOOT + 22'h000006, 5);
        ret();
        sleeping = 1'b1;
        hit(1);
        take(BOOT + 22'h000004, 10);
        sleeping = 1'b0;
        ret();
        finishTest();
    end
    // cut a hang short
    initial begin
        repeat (20000) @(posedge clock);
        badCount++;
        finishTest();
    end
endmodule : tb_top
bind cpu_interrupt_sequencer cpu_interrupt_sequencer_assertions #(.N(N))
    checker_i (.clock(clock), .rst_b(rst_b), .coreEvt(coreEvt),
    .globalEnWr(globalEnWr), .curSp(curSp), .globalEn(globalEn),
    .stallCore(stallCore), .pushReq(pushReq), .popReq(popReq),
    .spLoad(spLoad), .newSp(newSp), .pcLoad(pcLoad));
